// ===== fev_defines.svh
`ifndef FEV_DEFINES_SVH
`define FEV_DEFINES_SVH
// Summary of operation
// - Clearing the command complete flag launches a check that every phrase reads as erased.
// - The command complete flag sets again only once the whole check has finished.
// - A launch with the command object index not pointing at slot two is an access error.
// - A launch while a load-data-field sequence is active is an access error.
// - A launch in an operating mode that forbids the command is an access error.
// - A launch whose 23-bit start address is outside program flash is an access error.
// - A launch whose start address has any of bits 2:0 set is an access error.
// - A launch whose section crosses a 256 Kbyte boundary is an access error.
// - Any error while reading the section, not-erased data included, sets verify error status.
// - Any uncorrectable error while reading the section sets verify uncorrectable status.

////////////////////////////////////////////////////////////////////////////////
`define FEV_ADDR_W        8
`define FEV_OFF_STATUS    8'h00
`define FEV_OFF_INDEX     8'h04
`define FEV_OFF_OBJECT    8'h08
`define FEV_OFF_MODE      8'h0C
`define FEV_OFF_IRQ_STAT  8'h10
`define FEV_OFF_IRQ_CLR   8'h14
`define FEV_OFF_IRQ_EN    8'h18

`define FEV_ST_CCF        7
`define FEV_ST_ACCESS_ERROR_FLAG     5
`define FEV_ST_PROTECTION_VIOLATION_FLAG     4
`define FEV_ST_VERR       1
`define FEV_ST_VUNC       0
`define FEV_MODE_ALLOW    0
`define FEV_MODE_LDF      1
`define FEV_MODE_RESET    2'h1
`define FEV_IRQ_DONE      0
`define FEV_IRQ_ACCESS_ERROR_FLAG    1

`define FEV_CMD_CODE      8'h03
`define FEV_IDX_LAUNCH    3'h2
`define FEV_SLOTS         6
`define FEV_PFLASH_LO     24'h78_0000
`define FEV_PFLASH_HI     24'h7F_FFFF
`define FEV_RESP_OKAY     2'h0
`define FEV_RESP_SLVERR   2'h2
`endif

// ===== fev_pkg.sv
package fev_pkg;
  typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WAIT} fev_eng_state_t;
  typedef logic [15:0] fev_word_t;
endpackage : fev_pkg

// ===== fev_engine_if.sv
`timescale 1ns/10ps
interface fev_engine_if;
  logic        start;
  logic [19:0] startPhrase;
  logic [15:0] phraseCount;
  logic        done;
  logic        notErased;
  logic        uncorrectable;
  modport ctrl (output start, output startPhrase, output phraseCount,
                input done, input notErased, input uncorrectable);
  modport eng  (input start, input startPhrase, input phraseCount,
                output done, output notErased, output uncorrectable);
endinterface : fev_engine_if

// ===== fev_verify_engine.sv
`timescale 1ns/10ps
`include "fev_defines.svh"
module fev_verify_engine
  import fev_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  fev_engine_if.eng        eng,
  output logic             flashRdEn,
  output logic [19:0]      flashRdPhrase,
  input  wire logic [63:0] flashRdData,
  input  wire logic        flashRdValid,
  input  wire logic        flashRdUncorr
);
  fev_eng_state_t state;
  logic [15:0]    left;
  logic           notErased;
  logic           uncorr;
  logic           done;
  wire            phraseBad  = ~(&flashRdData) | flashRdUncorr;
  wire            lastPhrase = (left == 16'h0001);

  assign eng.done          = done;
  assign eng.notErased     = notErased;
  assign eng.uncorrectable = uncorr;

  // Each phrase is read once and compared against all ones; the next read waits
  // for the answer, which trades speed for a flash port without outstanding reads.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state         <= ENG_IDLE;
      left          <= 16'h0000;
      notErased     <= 1'b0;
      uncorr        <= 1'b0;
      done          <= 1'b0;
      flashRdEn     <= 1'b0;
      flashRdPhrase <= 20'h0_0000;
    end
    else
    begin
      done      <= 1'b0;
      flashRdEn <= 1'b0;
      unique case (state)
        ENG_IDLE:
          if (eng.start)
          begin
            flashRdPhrase <= eng.startPhrase;
            left          <= eng.phraseCount;
            notErased     <= 1'b0;
            uncorr        <= 1'b0;
            state         <= ENG_READ;
          end
        ENG_READ:
        begin
          flashRdEn <= 1'b1;
          state     <= ENG_WAIT;
        end
        ENG_WAIT:
          if (flashRdValid)
          begin
            if (phraseBad)
              notErased <= 1'b1;
            if (flashRdUncorr)
              uncorr <= 1'b1;
            flashRdPhrase <= flashRdPhrase + 20'h0_0001;
            left          <= left - 16'h0001;
            if (lastPhrase)
            begin
              done  <= 1'b1;
              state <= ENG_IDLE;
            end
            else
              state <= ENG_READ;
          end
      endcase
    end
  end
endmodule : fev_verify_engine

// ===== fev_top.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "fev_defines.svh"
module fev_top
  import fev_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic [`FEV_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`FEV_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       flashRdEn,
  output logic [19:0]                flashRdPhrase,
  input  wire logic [63:0]           flashRdData,
  input  wire logic                  flashRdValid,
  input  wire logic                  flashRdUncorr,
  output logic                       irq
);
  fev_engine_if engBus ();

  logic [`FEV_ADDR_W-1:0] wrAddr;
  logic [31:0]            wrData;
  logic [3:0]             wrStrb;
  logic                   cmdCompleteFlag;
  logic                   accessErrorFlag;
  logic                   verifyErrorStatus;
  logic                   verifyUncorrectableStatus;
  logic [2:0]             commandObjectIndex;
  fev_word_t              commandObjectArray [`FEV_SLOTS];
  logic [1:0]             modeReg;
  logic [1:0]             irqStat;
  logic [1:0]             irqEn;
  logic                   startPulse;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge so narrow software writes to an object slot leave the other lanes alone; other registers take zero there.
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    return res;
  endfunction : laneMerge

  ////////////////////////////////////////////////////////////////////////////////
  // Write path: address and data are taken in either order; the write lands
  // in the cycle both are held and no response is pending.
  wire doWrite   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wrStatus  = doWrite & (wrAddr == `FEV_OFF_STATUS);
  wire wrIndex   = doWrite & (wrAddr == `FEV_OFF_INDEX);
  wire wrObject  = doWrite & (wrAddr == `FEV_OFF_OBJECT);
  wire wrMode    = doWrite & (wrAddr == `FEV_OFF_MODE);
  wire wrIrqClr  = doWrite & (wrAddr == `FEV_OFF_IRQ_CLR);
  wire wrIrqEn   = doWrite & (wrAddr == `FEV_OFF_IRQ_EN);
  wire wrMapped  = wrStatus | wrIndex | wrObject | wrMode | wrIrqClr | wrIrqEn
                   | (wrAddr == `FEV_OFF_IRQ_STAT);
  wire [31:0] wrEff = laneMerge(32'h0000_0000, wrData, wrStrb);

  ////////////////////////////////////////////////////////////////////////////////
  // Launch checks, all evaluated against the object array, the index and the mode register as they stand.
  wire [23:0] startAddr  = {1'b0, commandObjectArray[0][6:0], commandObjectArray[1]};
  wire [15:0] phraseCnt  = commandObjectArray[2];
  wire [23:0] endAddr    = startAddr + {5'h00, phraseCnt, 3'h0} - 24'h00_0001;
  wire launchReq  = wrStatus & wrEff[`FEV_ST_CCF] & cmdCompleteFlag;
  wire badIndex   = commandObjectIndex != `FEV_IDX_LAUNCH;
  wire badLdf     = modeReg[`FEV_MODE_LDF];
  wire badMode    = ~modeReg[`FEV_MODE_ALLOW];
  wire badCode    = commandObjectArray[0][15:8] != `FEV_CMD_CODE;
  wire badAddr    = (startAddr < `FEV_PFLASH_LO) | (startAddr > `FEV_PFLASH_HI)
                    | (endAddr > `FEV_PFLASH_HI) | (phraseCnt == 16'h0000);
  wire badAlign   = startAddr[2:0] != 3'h0;
  wire badCross   = startAddr[22:18] != endAddr[22:18];
  wire launchErr  = badIndex | badLdf | badMode | badCode | badAddr | badAlign | badCross;
  wire launchOk   = launchReq & ~launchErr;
  wire launchFail = launchReq & launchErr;

  assign engBus.start       = startPulse;
  assign engBus.startPhrase = startAddr[22:3];
  assign engBus.phraseCount = phraseCnt;

  // Hardware set wins over a software clear in the same cycle.
  wire [1:0] irqEvents   = {launchFail, engBus.done};
  wire [1:0] irqClrBits  = wrIrqClr ? wrEff[1:0] : 2'b00;
  wire [1:0] next_irqStat = irqEvents | (irqStat & ~irqClrBits);
  wire [1:0] next_irqEn   = wrIrqEn ? wrEff[1:0] : irqEn;
  wire       accClr       = wrStatus & wrEff[`FEV_ST_ACCESS_ERROR_FLAG];

  ////////////////////////////////////////////////////////////////////////////////
  // Read path.
  wire [`FEV_ADDR_W-1:0] rAddr = s_axi_araddr;
  wire [31:0] statusWord = {24'h00_0000, cmdCompleteFlag, 1'b0, accessErrorFlag,
                            1'b0, 2'b00, verifyErrorStatus, verifyUncorrectableStatus};
  wire [15:0] objWord = (commandObjectIndex < 3'(`FEV_SLOTS))
                        ? commandObjectArray[commandObjectIndex] : 16'h0000;
  // A software write merges its byte lanes into the slot that the index selects.
  wire [31:0] objMerged = laneMerge({16'h0000, objWord}, wrData, wrStrb);
  wire rdStatus = rAddr == `FEV_OFF_STATUS;
  wire rdIndex  = rAddr == `FEV_OFF_INDEX;
  wire rdObject = rAddr == `FEV_OFF_OBJECT;
  wire rdMode   = rAddr == `FEV_OFF_MODE;
  wire rdIrqSt  = rAddr == `FEV_OFF_IRQ_STAT;
  wire rdIrqEn  = rAddr == `FEV_OFF_IRQ_EN;
  wire rdWo     = rAddr == `FEV_OFF_IRQ_CLR;
  wire rdMapped = rdStatus | rdIndex | rdObject | rdMode | rdIrqSt | rdIrqEn | rdWo;
  wire [31:0] rdMux = rdStatus ? statusWord
                    : rdIndex  ? {29'h0, commandObjectIndex}
                    : rdObject ? {16'h0000, objWord}
                    : rdMode   ? {30'h0, modeReg}
                    : rdIrqSt  ? {30'h0, irqStat}
                    : rdIrqEn  ? {30'h0, irqEn}
                    : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FEV_RESP_OKAY;
      wrAddr        <= '0;
      wrData        <= 32'h0000_0000;
      wrStrb        <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        wrAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wrData       <= s_axi_wdata;
        wrStrb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `FEV_RESP_OKAY : `FEV_RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `FEV_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdMux;
      s_axi_rresp   <= rdMapped ? `FEV_RESP_OKAY : `FEV_RESP_SLVERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      commandObjectIndex <= 3'h0;
      modeReg            <= `FEV_MODE_RESET;
      for (int i = 0; i < `FEV_SLOTS; i++)
        commandObjectArray[i] <= 16'h0000;
    end
    else
    begin
      if (wrIndex)
        commandObjectIndex <= wrEff[2:0];
      if (wrMode)
        modeReg <= wrEff[1:0];
      // Object writes while a command runs are dropped to keep the engine's inputs stable.
      if (wrObject & cmdCompleteFlag & (commandObjectIndex < 3'(`FEV_SLOTS)))
        commandObjectArray[commandObjectIndex] <= objMerged[15:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cmdCompleteFlag           <= 1'b1;
      accessErrorFlag           <= 1'b0;
      verifyErrorStatus         <= 1'b0;
      verifyUncorrectableStatus <= 1'b0;
      startPulse                <= 1'b0;
    end
    else
    begin
      startPulse <= launchOk;
      if (launchFail | accClr)
        accessErrorFlag <= launchFail;
      if (launchOk)
      begin
        cmdCompleteFlag           <= 1'b0;
        verifyErrorStatus         <= 1'b0;
        verifyUncorrectableStatus <= 1'b0;
      end
      else if (engBus.done)
      begin
        cmdCompleteFlag           <= 1'b1;
        verifyErrorStatus         <= engBus.notErased;
        verifyUncorrectableStatus <= engBus.uncorrectable;
      end
    end
  end
  // The protection violation bit of the status word is wired to zero.
  // A failed launch never pulses the engine, so no read occurs.

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      irqStat <= 2'b00;
      irqEn   <= 2'b00;
      irq     <= 1'b0;
    end
    else
    begin
      irqStat <= next_irqStat;
      irqEn   <= next_irqEn;
      irq     <= |(next_irqStat & next_irqEn);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  fev_verify_engine u_engine (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .eng           (engBus.eng),
    .flashRdEn     (flashRdEn),
    .flashRdPhrase (flashRdPhrase),
    .flashRdData   (flashRdData),
    .flashRdValid  (flashRdValid),
    .flashRdUncorr (flashRdUncorr)
  );
endmodule : fev_top

// ===== fev_top_monitor.sv
`timescale 1ns/10ps
module fev_top_monitor (
  input logic        clk_sys,
  input logic        reset,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        flashRdEn,
  input logic [19:0] flashRdPhrase,
  input logic        flashRdValid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // The previous read's phrase lets the walk through a section be checked.
  logic [19:0] lastPhrase;
  always_ff @(posedge clk_sys)
  begin
    if (flashRdEn)
    begin
      lastPhrase <= flashRdPhrase;
    end
  end
  ////////////////////////////////////////
  property p_rd_pulse;
    flashRdEn |=> !flashRdEn [*2];
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read request too close");
  property p_rd_next;
    flashRdValid ##2 flashRdEn |-> flashRdPhrase == lastPhrase + 20'h0_0001;
  endproperty
  a_rd_next: assert property (p_rd_next) else $error("phrase not consecutive");
  property p_rd_range;
    flashRdEn |-> flashRdPhrase[19:16] == 4'hF;
  endproperty
  a_rd_range: assert property (p_rd_range) else $error("read outside flash");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken early");
  c_walk: cover property (flashRdValid ##2 flashRdEn);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_access_error_flag: cover property (s_axi_rvalid && s_axi_rdata[5]);
endmodule : fev_top_monitor

bind fev_top fev_top_monitor mon_u (.clk_sys, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .flashRdEn, .flashRdPhrase,
  .flashRdValid);

// ===== flash_erase_verify_section_test.sv
`timescale 1ns/10ps
module flash_erase_verify_section_test;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [63:0] flashRdData = 64'h0000_0000_0000_0000;
  logic        flashRdValid = 1'b0, flashRdUncorr = 1'b0, pend = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, irqEn;
  logic [31:0] s_axi_rdata;
  logic        flashRdEn, irq, fire, expVerr, expVunc;
  logic [19:0] flashRdPhrase, expPh;
  // Verify bits survive a refused launch, so the bench remembers the last good result.
  logic [1:0]  vSt = 2'b00;
  int          fails = 0, n_compared = 0, nRd = 0, dly = 0, k, seed = 95;
  always #25 clk_sys = ~clk_sys;
  fev_top dut_u (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .flashRdEn, .flashRdPhrase, .flashRdData, .flashRdValid,
    .flashRdUncorr, .irq);
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic guard(input int n);
    if (n > 40)
    begin
      fails++;
      stop_test();
    end
  endtask : guard
  ////////////////////////////////////////
  // Flash array stand-in: random latency, and a random mix of clean, not-erased and
  // uncorrectable phrases. Between answers the data lines toggle so stale data never passes.
  always @(posedge clk_sys)
  begin
    k = $unsigned($random(seed)) % 4;
    fire = pend && dly == 0;
    flashRdValid <= fire;
    flashRdUncorr <= fire ? k == 2 : ~flashRdUncorr;
    flashRdData <= fire ? {{63{1'b1}}, k != 1} : ~flashRdData;
    expVerr = expVerr | (fire && (k == 1 || k == 2));
    expVunc = expVunc | (fire && k == 2);
    pend <= !reset && (flashRdEn || (pend && !fire));
    dly <= flashRdEn ? k : dly - 1;
    if (flashRdEn)
    begin
      chk({12'h000, flashRdPhrase}, {12'h000, expPh + nRd[19:0]}, "phrase");
      nRd++;
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       ha, hw, hb;
    logic [1:0] r;
    int         n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    n = 0;
    while (!hb)
    begin
      @(negedge clk_sys);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      n++;
      guard(n);
      @(posedge clk_sys);
      if (ha)
        s_axi_awvalid <= 1'b0;
      if (hw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0000_0000, r}, {30'h0000_0000, er}, "write response");
  endtask : axw
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    int   n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 1'b0;
    n = 0;
    while (!hr)
    begin
      @(negedge clk_sys);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      n++;
      guard(n);
      @(posedge clk_sys);
      if (ha)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rdk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e, "read data");
    chk({30'h0000_0000, r}, {30'h0000_0000, er}, "read response");
  endtask : rdk
  function automatic logic access_error_flag(input logic [22:0] st, input logic [15:0] c,
                                  input logic [2:0] ix, input logic [1:0] md);
    logic [23:0] e;
    e = {1'b0, st} + {5'h00, c, 3'h0} - 24'h00_0001;
    return ix != 3'h2 || md != 2'h1 || st[2:0] != 3'h0 || st < 23'h78_0000 ||
           e > 24'h7F_FFFF || c == 16'h0000 || st[22:18] != e[22:18];
  endfunction : access_error_flag
  ////////////////////////////////////////
  task automatic run(input logic [22:0] st, input logic [15:0] c, input logic [2:0] ix,
                     input logic [1:0] md);
    logic [31:0] s;
    logic [31:0] obj [3];
    logic [1:0]  r;
    logic        ae;
    int          n;
    ae = access_error_flag(st, c, ix, md);
    obj[0] = {16'h0000, 8'h03, 1'b0, st[22:16]};
    obj[1] = {16'h0000, st[15:0]};
    obj[2] = {16'h0000, c};
    axw(8'h0C, {30'h0000_0000, md}, 2'h0);
    axw(8'h18, {30'h0000_0000, irqEn}, 2'h0);
    for (int i = 0; i < 3; i++)
    begin
      axw(8'h04, 32'(i), 2'h0);
      axw(8'h08, obj[i], 2'h0);
    end
    axw(8'h04, {29'h0000_0000, ix}, 2'h0);
    expPh = st[22:3];
    nRd = 0;
    expVerr = 1'b0;
    expVunc = 1'b0;
    axw(8'h00, 32'h0000_0080, 2'h0);
    s = 32'h0000_0000;
    n = 0;
    while (s[7] !== 1'b1)
    begin
      rd(8'h00, s, r);
      n++;
      guard(n);
    end
    chk(s, {24'h00_0000, 2'b10, ae, 3'h0, ae ? vSt : {expVerr, expVunc}}, "status");
    if (!ae)
      vSt = {expVerr, expVunc};
    chk(32'(nRd), ae ? 32'h0000_0000 : {16'h0000, c}, "read count");
    chk({31'h0000_0000, irq}, {31'h0000_0000, |(irqEn & {ae, !ae})}, "irq");
    axw(8'h10, 32'h0000_0000, 2'h0);
    rdk(8'h10, {30'h0000_0000, ae, !ae}, 2'h0);
    axw(8'h14, 32'h0000_0003, 2'h0);
    axw(8'h00, 32'h0000_0020, 2'h0);
    rdk(8'h00, {24'h00_0000, 6'h20, vSt}, 2'h0);
    chk({31'h0000_0000, irq}, 32'h0000_0000, "irq cleared");
  endtask : run
  initial
  begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rdk(8'h00, 32'h0000_0080, 2'h0);
    rdk(8'h0C, 32'h0000_0001, 2'h0);
    axw(8'h1C, 32'hFFFF_FFFF, 2'h2);
    rdk(8'h1C, 32'h0000_0000, 2'h2);
    irqEn = 2'h3;
    run(23'h78_0000, 16'h0001, 3'h2, 2'h1);
    run(23'h7F_FFC0, 16'h0008, 3'h2, 2'h1);
    for (int i = 0; i < 6; i++)
    begin
      irqEn = i[1:0];
      run({4'hF, 16'($random(seed)), 3'h0}, 16'($unsigned($random(seed)) % 8 + 1),
          3'h2, 2'h1);
    end
    irqEn = 2'h2;
    run(23'h78_0000, 16'h0004, 3'h1, 2'h1);
    run(23'h78_0000, 16'h0004, 3'h2, 2'h3);
    run(23'h78_0000, 16'h0004, 3'h2, 2'h0);
    run(23'h70_0000, 16'h0004, 3'h2, 2'h1);
    run(23'h78_0004, 16'h0004, 3'h2, 2'h1);
    run(23'h7B_FFF8, 16'h0002, 3'h2, 2'h1);
    run(23'h7F_FFF8, 16'h0002, 3'h2, 2'h1);
    run(23'h78_0000, 16'h0002, 3'h2, 2'h1);
    stop_test();
  end
endmodule : flash_erase_verify_section_test
